//--- logic/clkld_consts.svh
`ifndef CLKLD_CONSTS_SVH
`define CLKLD_CONSTS_SVH

// core clock period in ns (25 MHz)
`define CLKLD_CORE_PERIOD_NS   40
// loss-of-signal assert time, ns, longest and typical
`define CLKLD_LOSS_ASSERT_NS   300
`define CLKLD_LOSS_TYP_NS      240
// longest time rounds down to whole core cycles
`define CLKLD_LOSS_CYCLES      (`CLKLD_LOSS_ASSERT_NS / `CLKLD_CORE_PERIOD_NS)
// cycles lost to the toggle crossing and the output register
`define CLKLD_LOSS_SYNC_CYCLES 3
// loss-of-signal deassert time, input-clock cycles, longest and typical
`define CLKLD_DEASSERT_CLKS    7
`define CLKLD_DEASSERT_TYP     6
// enable latency, input-clock cycles
`define CLKLD_OE_LAT_MIN       4
`define CLKLD_OE_LAT_MAX       6
// startup after power-good release, ns, and after supply ramp, ms
`define CLKLD_STARTUP_NS       87
`define CLKLD_STARTUP_TYP_NS   70
`define CLKLD_STARTUP_MS       1.6
// width of the input-clock divider feeding the presence toggle
`define CLKLD_TOG_DIV_W        2
// width of the idle counter
`define CLKLD_IDLE_W           4

`endif

//--- logic/clkld_lane.sv
`timescale 1ns/1ps
`include "clkld_consts.svh"

module clkld_lane
  import clkld_pkg::*;
(
  // input clock domain
  input  wire logic ref_clk,
  input  wire logic ref_rst,
  // control
  input  wire logic output_enable_n,
  input  wire logic run,
  input  wire logic hold_high,
  // output pair
  output logic      out_p,
  output logic      out_n
);

  clkld_lane_s state_reg;
  clkld_lane_s state_next;
  logic        en;

  always_comb
  begin
    state_next         = state_reg;
    // two sync flops plus two delay flops land the change at the output on edge 5
    state_next.oe_sync = {state_reg.oe_sync[0], output_enable_n};
    state_next.oe_dly  = {state_reg.oe_dly[0], state_reg.oe_sync[1]};
    en                 = run & ~state_reg.oe_dly[1];
    if (hold_high)
    begin
      state_next.p = 1'b1;
      state_next.n = 1'b0;
    end
    else if (state_reg.p)
    begin
      // a high phase always completes, so a stop never cuts a pulse short
      state_next.p = 1'b0;
      state_next.n = en;
    end
    else
    begin
      state_next.p = en;
      state_next.n = 1'b0;
    end
    if (ref_rst)
    begin
      state_next = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    state_reg <= state_next;
  end

  assign out_p = state_reg.p;
  assign out_n = state_reg.n;

endmodule // clkld_lane

//--- logic/clkld_pkg.sv
package clkld_pkg;

  // one output lane, input-clock domain
  typedef struct packed {
    logic [1:0] oe_sync;
    logic [1:0] oe_dly;
    logic       p;
    logic       n;
  } clkld_lane_s;

  // input-clock domain of the top
  typedef struct packed {
    logic [1:0] rst_sync;
    logic       alive;
    logic [1:0] pg_sync;
    logic [1:0] lost_sync;
    logic [1:0] div;
    logic       tog;
  } clkld_ref_s;

  // core-clock domain of the top
  typedef struct packed {
    logic [2:0] tog_sync;
    logic       armed;
    logic       lost;
    logic [3:0] idle;
    logic [1:0] park_en_sync;
    logic [1:0] pg_sync;
    logic       park;
  } clkld_core_s;

endpackage

//--- logic/clkld_top.sv
`timescale 1ns/1ps
`include "clkld_consts.svh"

module clkld_top
  import clkld_pkg::*;
#(
  parameter int NUM_OUT = 8
)
(
  // core clock and reset
  input  wire logic               core_clk,
  input  wire logic               resetn,
  // input reference clock
  input  wire logic               ref_clk,
  // pins
  input  wire logic [NUM_OUT-1:0] output_enable_n,
  input  wire logic               power_good_powerdown_n,
  input  wire logic               park_on_loss_enable,
  // outputs
  output logic [NUM_OUT-1:0]      clk_out_p,
  output logic [NUM_OUT-1:0]      clk_out_n,
  output logic                    input_clock_lost
);

  localparam logic [`CLKLD_IDLE_W-1:0] LOSS_IDLE =
    `CLKLD_IDLE_W'(`CLKLD_LOSS_CYCLES - `CLKLD_LOSS_SYNC_CYCLES);

  clkld_ref_s         ref_reg;
  clkld_ref_s         ref_next;
  clkld_core_s        core_reg;
  clkld_core_s        core_next;
  logic               ref_rst;
  logic               run;
  logic               hold_high;
  logic               seen;
  logic [NUM_OUT-1:0] lane_p;
  logic [NUM_OUT-1:0] lane_n;

  assign ref_rst   = ~ref_reg.rst_sync[1];
  // outputs run as soon as power good is seen on the input clock
  assign run       = ref_reg.alive & ref_reg.pg_sync[1];
  assign hold_high = run & ref_reg.lost_sync[1];

  // input-clock domain: reset release, presence toggle, crossings
  always_comb
  begin
    ref_next           = ref_reg;
    ref_next.rst_sync  = {ref_reg.rst_sync[0], resetn};
    ref_next.pg_sync   = {ref_reg.pg_sync[0], power_good_powerdown_n};
    ref_next.lost_sync = {ref_reg.lost_sync[0], core_reg.lost};
    // internal reset is held until the first edge after release
    ref_next.alive     = 1'b1;
    // divided so each toggle level outlasts one core period
    ref_next.div       = ref_reg.div + 2'h1;
    if (ref_reg.div == 2'h0)
    begin
      ref_next.tog = ~ref_reg.tog;
    end
    if (ref_rst)
    begin
      ref_next          = '0;
      ref_next.rst_sync = {ref_reg.rst_sync[0], resetn};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    ref_reg <= ref_next;
  end

  // core domain: edge-presence watchdog and parking
  always_comb
  begin
    core_next              = core_reg;
    core_next.tog_sync     = {core_reg.tog_sync[1:0], ref_reg.tog};
    core_next.park_en_sync = {core_reg.park_en_sync[0], park_on_loss_enable};
    core_next.pg_sync      = {core_reg.pg_sync[0], power_good_powerdown_n};
    // any toggle counts as presence; its rate is never judged
    seen                   = core_reg.tog_sync[2] ^ core_reg.tog_sync[1];
    if (seen)
    begin
      core_next.armed = 1'b1;
      core_next.idle  = '0;
      core_next.lost  = 1'b0;
    end
    else if (core_reg.armed && core_reg.idle != LOSS_IDLE)
    begin
      core_next.idle = core_reg.idle + `CLKLD_IDLE_W'(1);
      if (core_reg.idle == LOSS_IDLE - `CLKLD_IDLE_W'(1))
      begin
        core_next.lost = 1'b1;
      end
    end
    core_next.park = core_next.lost & core_reg.park_en_sync[1] & core_reg.pg_sync[1];
    if (!resetn)
    begin
      core_next          = '0;
      core_next.tog_sync = {core_reg.tog_sync[1:0], ref_reg.tog};
    end
  end

  always_ff @(posedge core_clk)
  begin
    core_reg <= core_next;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_lane
      clkld_lane u_lane (
        .ref_clk         (ref_clk),
        .ref_rst         (ref_rst),
        .output_enable_n (output_enable_n[gi]),
        .run             (run),
        .hold_high       (hold_high),
        .out_p           (lane_p[gi]),
        .out_n           (lane_n[gi])
      );
    end
  endgenerate

  // parking must act while the input clock is stopped, so it gates from the core side
  assign clk_out_p        = lane_p & {NUM_OUT{~core_reg.park}};
  assign clk_out_n        = lane_n & {NUM_OUT{~core_reg.park}};
  // the ref side drops the flag once it has seen the loss; the slow core alone cannot meet the deassert time
  // limitation: a ref slower than the idle window makes the flag flicker
  assign input_clock_lost = core_reg.lost & ~ref_reg.lost_sync[1];

endmodule // clkld_top

//--- tb/clkld_checker.sv
`timescale 1ns/1ps
module clkld_checker
  import clkld_pkg::*;
#(parameter int NUM_OUT = 8)
(
  // clocks and reset
  input wire logic               core_clk,
  input wire logic               resetn,
  input wire logic               ref_clk,
  // pins
  input wire logic [NUM_OUT-1:0] output_enable_n,
  input wire logic               power_good_powerdown_n,
  input wire logic               park_on_loss_enable,
  // outputs
  input wire logic [NUM_OUT-1:0] clk_out_p,
  input wire logic [NUM_OUT-1:0] clk_out_n,
  input wire logic               input_clock_lost
);
  wire        lost = input_clock_lost;
  wire        pg   = power_good_powerdown_n;
  logic [2:0] rc_reg = 3'h0;
  logic [2:0] sync_reg;
  logic [3:0] idle_reg;
  logic       seen_reg;
  // bit 2 changes slower than the core samples, so a live input never looks idle
  always @(posedge ref_clk) rc_reg <= rc_reg + 3'h1;
  always_ff @(posedge core_clk)
  begin
    sync_reg <= {sync_reg[1:0], rc_reg[2]};
    if (!resetn)
    begin
      idle_reg <= 4'h0;
      seen_reg <= 1'b0;
    end
    else if (sync_reg[2] != sync_reg[1])
    begin
      idle_reg <= 4'h0;
      seen_reg <= 1'b1;
    end
    else if (idle_reg != 4'hF)
      idle_reg <= idle_reg + 4'h1;
  end
  loss_assert_a: assert property (@(posedge core_clk) disable iff (!resetn)
    idle_reg >= 4'h7 && rc_reg == $past(rc_reg) |-> lost) else $error("loss flag late");
  armed_first_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !seen_reg |-> !lost) else $error("loss flag before first edge");
  loss_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    lost |-> ##[1:7] !lost) else $error("loss flag clears late");
  park_low_a: assert property (@(posedge core_clk) disable iff (!resetn)
    lost && $past(lost) && park_on_loss_enable && $past(park_on_loss_enable, 3) && pg && $past(pg, 3)
    |-> (clk_out_p | clk_out_n) == '0) else $error("outputs not parked");
  hold_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(lost) && pg |=> clk_out_n == '0 && (park_on_loss_enable || clk_out_p == '1))
    else $error("no high/low hold on recovery");
  legs_apart_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_out_p & clk_out_n) == '0) else $error("both legs high");
  oe_start_a: assert property (@(posedge ref_clk) disable iff (!resetn || !pg || lost)
    $fell(output_enable_n[0]) |-> !clk_out_p[0] [*3] ##[1:3] clk_out_p[0]) else $error("start latency");
  oe_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn || !pg || lost)
    $rose(output_enable_n[0]) |-> ##[4:6] !(clk_out_p[0] | clk_out_n[0])) else $error("stop latency");
  startup_a: assert property (@(posedge ref_clk) disable iff (!resetn || lost)
    $rose(pg) && !output_enable_n[0] |-> ##[1:6] clk_out_p[0]) else $error("startup late");
endmodule // clkld_checker
bind clkld_top clkld_checker #(.NUM_OUT(NUM_OUT)) clkld_checker_i (.core_clk, .resetn, .ref_clk,
  .output_enable_n, .power_good_powerdown_n, .park_on_loss_enable, .clk_out_p, .clk_out_n, .input_clock_lost);

//--- tb/clkld_ref_source.sv
`timescale 1ns/1ps
module clkld_ref_source
(
  // control
  input wire logic run,
  // reference clock
  output logic     ref_clk
);
  // stands still low while stopped, so no stray edge reaches the detector
  initial
  begin
    ref_clk = 1'b0;
    #3.1;
    forever #6 ref_clk = run ? ~ref_clk : 1'b0;
  end
endmodule // clkld_ref_source

//--- tb/clock_loss_detect_and_output_gating_test.sv
`timescale 1ns/1ps
module clock_loss_detect_and_output_gating_test;
  logic       core_clk, resetn, ref_clk, run, power_good_powerdown_n, park_on_loss_enable, input_clock_lost;
  logic [7:0] output_enable_n, clk_out_p, clk_out_n;
  int         err_total, check_count;
  clkld_ref_source clkld_ref_source_i (.run, .ref_clk);
  clkld_top clkld_top_i (.core_clk, .resetn, .ref_clk, .output_enable_n, .power_good_powerdown_n,
    .park_on_loss_enable, .clk_out_p, .clk_out_n, .input_clock_lost);
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // outputs are read mid-cycle, clear of the park flop's edge
  task automatic wc(input int k);
    repeat (k) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task run_lanes;
    @(posedge core_clk) output_enable_n <= 8'hFA;
    wc(4);
    chk("lanes on", 8'h05, clk_out_p | clk_out_n);
    @(posedge core_clk) output_enable_n <= 8'hFB;
    wc(4);
    chk("lane0 off", 8'h04, clk_out_p | clk_out_n);
    @(posedge core_clk) output_enable_n <= 8'hFE;
    wc(4);
    chk("lane swap", 8'h01, clk_out_p | clk_out_n);
  endtask
  task loss_park(input logic en);
    @(posedge core_clk) park_on_loss_enable <= en;
    wc(4);
    run = 1'b0;
    wc(10);
    chk("lost set", 8'h01, {7'h0, input_clock_lost});
    if (en) chk("parked", 8'h00, clk_out_p | clk_out_n);
    run = 1'b1;
    wc(3);
    chk("lost clear", 8'h00, {7'h0, input_clock_lost});
    wc(2);
    chk("resumed", 8'h01, clk_out_p | clk_out_n);
  endtask
  task pg_cycle;
    @(posedge core_clk) power_good_powerdown_n <= 1'b0;
    wc(2);
    chk("pg low", 8'h00, clk_out_p | clk_out_n);
    @(posedge core_clk) power_good_powerdown_n <= 1'b1;
    wc(2);
    chk("pg start", 8'h01, clk_out_p | clk_out_n);
  endtask
  task tally_and_finish;
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    wc(4000);
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    {resetn, park_on_loss_enable, err_total, check_count} = '0;
    {run, power_good_powerdown_n, output_enable_n} = 10'h3FF;
    wc(16);
    @(posedge core_clk) resetn <= 1'b1;
    wc(4);
    chk("armed", 8'h00, {7'h0, input_clock_lost});
    run_lanes;
    loss_park(1'b1);
    loss_park(1'b0);
    pg_cycle;
    tally_and_finish;
  end
endmodule // clock_loss_detect_and_output_gating_test
